/* File: design/cio_decoder.v */
`include "cio_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module cio_decoder
(
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire        instr_valid,
    input  wire [13:0] instr,
    input  wire [7:0]  mem_rdata,
    input  wire        mem_ready,
    input  wire [7:0]  file_rdata,
    output wire        instr_ready,
    output reg  [1:0]  pc_op,
    output reg  [14:0] pc_target,
    output reg         pc_load,
    output reg  [15:0] mem_addr,
    output reg         mem_rd,
    output reg         mem_wr,
    output reg  [7:0]  mem_wdata,
    output reg  [6:0]  file_addr,
    output reg         file_wr,
    output reg  [7:0]  file_wdata,
    output reg  [7:0]  acc,
    output reg  [15:0] ptr0,
    output reg  [15:0] ptr1,
    output reg  [7:0]  prescale_cfg,
    output reg  [63:0] pin_dir,
    output reg         carry_flag,
    output reg         nibble_outflow_flag,
    output reg         zero_flag,
    output reg         expiry_flag,
    output reg         sleep_entered_flag,
    output reg         standby,
    output reg         watchdog_kick
);

    // PC operation codes towards the fetch unit.
    localparam [1:0] PC_NONE = 2'h0;
    localparam [1:0] PC_JUMP = 2'h1;
    localparam [1:0] PC_CALL = 2'h2;
    localparam [1:0] PC_RET  = 2'h3;

    // Execute states.
    localparam [1:0] ST_EXEC  = 2'h0;
    localparam [1:0] ST_FLUSH = 2'h1;
    localparam [1:0] ST_MEM   = 2'h2;

    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg         pend_load;

    // Shared pointer arithmetic, sixteen-bit wrap for all modes.
    function [15:0] ptr_add;
        input [15:0] base;
        input [15:0] offs;
        begin
            ptr_add = base + offs;
        end
    endfunction

    function [15:0] sext6;
        input [5:0] k;
        begin
            sext6 = {{10{k[5]}}, k};
        end
    endfunction

    wire [13:0] w = instr;
    wire        is_rel_jump   = (w[13:9] == `CIO_PFX_REL_JUMP);
    wire        is_rel_acc    = (w == `CIO_OP_REL_JUMP_ACC);
    wire        is_call       = (w[13:11] == `CIO_PFX_SUB_JUMP);
    wire        is_absolute_jump       = (w[13:11] == `CIO_PFX_ABS_JUMP);
    wire        is_call_acc   = (w == `CIO_OP_SUB_JUMP_ACC);
    wire        is_const_exit = (w[13:8] == `CIO_PFX_CONST_EXIT);
    wire        is_sub_exit   = (w == `CIO_OP_SUB_EXIT);
    wire        is_int_exit   = (w == `CIO_OP_INT_EXIT);
    wire        is_standby    = (w == `CIO_OP_STANDBY);
    wire        is_kick       = (w == `CIO_OP_WDT_KICK);
    wire        is_prescale   = (w == `CIO_OP_PRESCALE_LOAD);
    // Selectors 2 to 4 share their words with the fixed inherent opcodes, which take priority.
    wire        is_dir_load   = (w[13:3] == `CIO_PFX_DIR_LOAD)
                              & ~is_prescale & ~is_standby & ~is_kick;
    wire        is_ptr_add    = (w[13:7] == `CIO_PFX_PTR_ADD);
    wire        is_ind_mod    = (w[13:4] == `CIO_PFX_IND_MOD);
    wire        is_ind_load   = is_ind_mod & ~w[3];
    wire        is_ind_store  = is_ind_mod & w[3];
    wire        is_idx_load   = (w[13:7] == `CIO_PFX_IDX_LOAD);
    wire        is_idx_store  = (w[13:7] == `CIO_PFX_IDX_STORE);
    wire        is_and_const  = (w[13:8] == `CIO_PFX_AND_CONST);
    wire        is_add_const  = (w[13:8] == `CIO_PFX_ADD_CONST);
    wire        is_and_file   = (w[13:8] == `CIO_PFX_AND_FILE);

    // Pointer selector sits in bit 2 for modifier forms, bit 6 for the rest.
    wire        sel_n   = is_ind_mod ? w[2] : w[6];
    wire [15:0] sel_ptr = sel_n ? ptr1 : ptr0;
    wire [1:0]  mode    = w[1:0];
    wire        pre_mod = (mode == `CIO_MODE_PRE_INC) | (mode == `CIO_MODE_PRE_DEC);
    wire [15:0] step    = mode[0] ? 16'hFFFF : 16'h0001;
    wire [15:0] mod_ptr = ptr_add(sel_ptr, step);
    wire [15:0] ind_addr = is_ind_mod ? (pre_mod ? mod_ptr : sel_ptr)
                                      : ptr_add(sel_ptr, sext6(w[5:0]));
    wire        is_ind  = is_ind_load | is_ind_store | is_idx_load | is_idx_store;
    wire        changes_pc = is_rel_jump | is_rel_acc | is_call | is_absolute_jump | is_call_acc
                           | is_const_exit | is_sub_exit | is_int_exit;
    wire [8:0]  add_res = {1'b0, acc} + {1'b0, w[7:0]};
    wire [4:0]  nib_res = {1'b0, acc[3:0]} + {1'b0, w[3:0]};
    wire [7:0]  and_file_res = acc & file_rdata;

    wire        take = instr_valid & (state == ST_EXEC);
    // Memory reads and writes in the upper half of the pointer space stall until mem_ready.
    assign instr_ready = (state == ST_EXEC);

    always @*
    begin
        next_state = state;
        case (state)
            ST_EXEC:
            begin
                if (take & changes_pc)
                    next_state = ST_FLUSH;
                else if (take & is_ind & ind_addr[15])
                    next_state = ST_MEM;
            end
            ST_FLUSH:
                next_state = ST_EXEC;
            ST_MEM:
            begin
                if (mem_ready)
                    next_state = ST_EXEC;
            end
            default:
                next_state = ST_EXEC;
        endcase
    end

    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state               <= ST_EXEC;
            pend_load           <= 1'b0;
            pc_op               <= PC_NONE;
            pc_target           <= 15'h0000;
            pc_load             <= 1'b0;
            mem_addr            <= `CIO_RST_PTR;
            mem_rd              <= 1'b0;
            mem_wr              <= 1'b0;
            mem_wdata           <= `CIO_RST_ACC;
            file_addr           <= 7'h00;
            file_wr             <= 1'b0;
            file_wdata          <= `CIO_RST_ACC;
            acc                 <= `CIO_RST_ACC;
            ptr0                <= `CIO_RST_PTR;
            ptr1                <= `CIO_RST_PTR;
            prescale_cfg        <= `CIO_RST_PRESCALE;
            pin_dir             <= {`CIO_DIR_COUNT{`CIO_RST_DIR}};
            carry_flag          <= 1'b0;
            nibble_outflow_flag <= 1'b0;
            zero_flag           <= 1'b0;
            expiry_flag         <= 1'b1;
            sleep_entered_flag  <= 1'b1;
            standby             <= 1'b0;
            watchdog_kick       <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            pc_op         <= PC_NONE;
            pc_load       <= 1'b0;
            mem_rd        <= 1'b0;
            mem_wr        <= 1'b0;
            file_wr       <= 1'b0;
            standby       <= 1'b0;
            watchdog_kick <= 1'b0;
            // Deferred load finishes once the slow memory answers.
            if (state == ST_MEM && mem_ready && pend_load)
            begin
                acc       <= mem_rdata;
                zero_flag <= (mem_rdata == 8'h00);
                pend_load <= 1'b0;
            end
            if (take)
            begin
                if (is_rel_jump)
                begin
                    pc_op     <= PC_JUMP;
                    pc_load   <= 1'b1;
                    pc_target <= {{6{w[8]}}, w[8:0]};
                end
                if (is_rel_acc)
                begin
                    pc_op     <= PC_JUMP;
                    pc_load   <= 1'b1;
                    pc_target <= {7'h00, acc};
                end
                if (is_call | is_absolute_jump)
                begin
                    pc_op     <= is_call ? PC_CALL : PC_JUMP;
                    pc_load   <= 1'b1;
                    pc_target <= {4'h0, w[10:0]};
                end
                if (is_call_acc)
                begin
                    pc_op     <= PC_CALL;
                    pc_load   <= 1'b1;
                    pc_target <= {7'h00, acc};
                end
                if (is_const_exit | is_sub_exit | is_int_exit)
                begin
                    pc_op     <= PC_RET;
                    pc_load   <= 1'b1;
                    pc_target <= {14'h0000, is_int_exit};
                end
                if (is_const_exit)
                    acc <= w[7:0];
                if (is_standby)
                begin
                    expiry_flag        <= 1'b1;
                    sleep_entered_flag <= 1'b0;
                    standby            <= 1'b1;
                end
                if (is_kick)
                begin
                    expiry_flag        <= 1'b1;
                    sleep_entered_flag <= 1'b1;
                    watchdog_kick      <= 1'b1;
                end
                if (is_prescale)
                    prescale_cfg <= acc;
                if (is_dir_load)
                    pin_dir[w[2:0]*8 +: 8] <= acc;
                if (is_ptr_add)
                begin
                    if (sel_n)
                        ptr1 <= ptr_add(ptr1, sext6(w[5:0]));
                    else
                        ptr0 <= ptr_add(ptr0, sext6(w[5:0]));
                end
                if (is_ind_mod)
                begin
                    if (sel_n)
                        ptr1 <= mod_ptr;
                    else
                        ptr0 <= mod_ptr;
                end
                if (is_ind)
                begin
                    mem_addr  <= ind_addr;
                    mem_rd    <= is_ind_load | is_idx_load;
                    mem_wr    <= is_ind_store | is_idx_store;
                    mem_wdata <= acc;
                    pend_load <= ind_addr[15] & (is_ind_load | is_idx_load);
                    // Low half reads complete combinationally in this cycle.
                    if ((is_ind_load | is_idx_load) & ~ind_addr[15])
                    begin
                        acc       <= mem_rdata;
                        zero_flag <= (mem_rdata == 8'h00);
                    end
                end
                if (is_and_const)
                begin
                    acc       <= acc & w[7:0];
                    zero_flag <= ((acc & w[7:0]) == 8'h00);
                end
                if (is_add_const)
                begin
                    acc                 <= add_res[7:0];
                    carry_flag          <= add_res[8];
                    nibble_outflow_flag <= nib_res[4];
                    zero_flag           <= (add_res[7:0] == 8'h00);
                end
                if (is_and_file)
                begin
                    zero_flag <= (and_file_res == 8'h00);
                    if (w[7])
                    begin
                        file_addr  <= w[6:0];
                        file_wr    <= 1'b1;
                        file_wdata <= and_file_res;
                    end
                    else
                        acc <= and_file_res;
                end
            end
        end
    end

endmodule

`default_nettype wire

/* File: common/cio_defs.vh */
`ifndef CIO_DEFS_VH
`define CIO_DEFS_VH

// Fixed opcode words.
`define CIO_OP_REL_JUMP_ACC   14'h000B
`define CIO_OP_SUB_JUMP_ACC   14'h000A
`define CIO_OP_INT_EXIT       14'h0009
`define CIO_OP_SUB_EXIT       14'h0008
`define CIO_OP_STANDBY        14'h0063
`define CIO_OP_WDT_KICK       14'h0064
`define CIO_OP_PRESCALE_LOAD  14'h0062
// Prefixes, compared against the top bits of the word.
`define CIO_PFX_REL_JUMP      5'h19
`define CIO_PFX_SUB_JUMP      3'h4
`define CIO_PFX_ABS_JUMP      3'h5
`define CIO_PFX_CONST_EXIT    6'h34
`define CIO_PFX_DIR_LOAD      11'h00C
`define CIO_PFX_PTR_ADD       7'h62
`define CIO_PFX_IND_MOD       10'h001
`define CIO_PFX_IDX_LOAD      7'h7E
`define CIO_PFX_IDX_STORE     7'h7F
`define CIO_PFX_AND_CONST     6'h39
`define CIO_PFX_ADD_CONST     6'h3E
`define CIO_PFX_AND_FILE      6'h05
// Pointer modifier modes.
`define CIO_MODE_PRE_INC      2'h0
`define CIO_MODE_PRE_DEC      2'h1
`define CIO_MODE_POST_INC     2'h2
`define CIO_MODE_POST_DEC     2'h3
// Reset values.
`define CIO_RST_ACC           8'h00
`define CIO_RST_PTR           16'h0000
`define CIO_RST_PRESCALE      8'hFF
`define CIO_RST_DIR           8'hFF
// Number of pin direction registers.
`define CIO_DIR_COUNT         8

`endif

/* File: testbench/cio_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cio_mem_model #(
    parameter int LAT = 3
) (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       instr_ready,
    input  wire logic [7:0] data,
    output logic      [7:0] mem_rdata,
    output logic            mem_ready
);
    int cnt;
    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            cnt <= 0;
        else
            cnt <= instr_ready ? 0 : cnt + 1;
    end
    // A slow answer to an upper-half access; a stale value is inverted so it never matches.
    assign mem_ready = (cnt == LAT);
    assign mem_rdata = (instr_ready || mem_ready) ? data : ~data;
endmodule
`default_nettype wire

/* File: testbench/cio_decoder_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cio_decoder_sva (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        instr_valid,
    input wire logic [13:0] instr,
    input wire logic        instr_ready,
    input wire logic [1:0]  pc_op,
    input wire logic [14:0] pc_target,
    input wire logic [7:0]  acc,
    input wire logic [15:0] ptr0,
    input wire logic        carry_flag,
    input wire logic        zero_flag,
    input wire logic [7:0]  prescale_cfg,
    input wire logic        expiry_flag,
    input wire logic        sleep_entered_flag,
    input wire logic        mem_ready,
    input wire logic        file_wr
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire t = instr_valid && instr_ready;
    chk_call_gap: assert property (t && instr[13:11] == 3'h4 |=>
        (pc_op == 2'h2 && !instr_ready) ##1 (instr_ready && pc_op == 2'h0)) else $error("call gap");
    chk_rel_target: assert property (t && instr[13:9] == 5'h19 |=> pc_op == 2'h1 &&
        pc_target == {{6{$past(instr[8])}}, $past(instr[8:0])}) else $error("relative target");
    chk_const_exit: assert property (t && instr[13:8] == 6'h34 |=>
        pc_op == 2'h3 && acc == $past(instr[7:0])) else $error("constant exit");
    chk_kick_flags: assert property (t && instr == 14'h0064 |=>
        expiry_flag && sleep_entered_flag) else $error("kick flags");
    chk_sleep_flags: assert property (t && instr == 14'h0063 |=>
        expiry_flag && !sleep_entered_flag) else $error("standby flags");
    chk_and_zero: assert property (t && instr[13:8] == 6'h39 |=>
        acc == ($past(acc) & $past(instr[7:0])) && zero_flag == (acc == 8'h00)) else $error("and");
    chk_add_carry: assert property (t && instr[13:8] == 6'h3E |=>
        {carry_flag, acc} == {1'b0, $past(acc)} + {1'b0, $past(instr[7:0])}) else $error("add");
    chk_prescale_load: assert property (t && instr == 14'h0062 |=>
        prescale_cfg == $past(acc) && $stable(zero_flag)) else $error("prescale");
    chk_ptr_add: assert property (t && instr[13:6] == 8'hC4 |=>
        ptr0 == $past(ptr0) + {{10{$past(instr[5])}}, $past(instr[5:0])}) else $error("pointer add");
    cov_jump: cover property (t && instr[13:11] == 3'h5);
    cov_stall: cover property (!instr_ready && mem_ready);
    cov_file_wr: cover property (file_wr);
endmodule
bind cio_decoder cio_decoder_sva u_cio_decoder_sva (.sys_clk(sys_clk), .rstn(rstn),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .pc_op(pc_op),
    .pc_target(pc_target), .acc(acc), .ptr0(ptr0), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .prescale_cfg(prescale_cfg), .expiry_flag(expiry_flag),
    .sleep_entered_flag(sleep_entered_flag), .mem_ready(mem_ready), .file_wr(file_wr));
`default_nettype wire

/* File: testbench/cio_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module cio_decoder_tb;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        instr_valid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [7:0]  file_rdata = 8'h00;
    logic [7:0]  mv = 8'h00;
    wire  [7:0]  mem_rdata, mem_wdata, file_wdata, acc, prescale_cfg;
    wire  [15:0] mem_addr, ptr0, ptr1;
    wire  [14:0] pc_target;
    wire  [63:0] pin_dir;
    wire  [6:0]  file_addr;
    wire  [1:0]  pc_op;
    wire         mem_ready, instr_ready, pc_load, mem_rd, mem_wr, file_wr, carry_flag;
    wire         nibble_outflow_flag, zero_flag, expiry_flag, sleep_entered_flag;
    wire         standby, watchdog_kick;
    int          err_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    cio_decoder u_cio_decoder (.sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid),
        .instr(instr), .mem_rdata(mem_rdata), .mem_ready(mem_ready), .file_rdata(file_rdata),
        .instr_ready(instr_ready), .pc_op(pc_op), .pc_target(pc_target), .pc_load(pc_load),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .file_addr(file_addr), .file_wr(file_wr), .file_wdata(file_wdata), .acc(acc),
        .ptr0(ptr0), .ptr1(ptr1), .prescale_cfg(prescale_cfg), .pin_dir(pin_dir),
        .carry_flag(carry_flag), .nibble_outflow_flag(nibble_outflow_flag),
        .zero_flag(zero_flag), .expiry_flag(expiry_flag),
        .sleep_entered_flag(sleep_entered_flag), .standby(standby),
        .watchdog_kick(watchdog_kick));
    cio_mem_model #(.LAT(3)) u_cio_mem_model (.sys_clk(sys_clk), .rstn(rstn),
        .instr_ready(instr_ready), .data(mv), .mem_rdata(mem_rdata), .mem_ready(mem_ready));
    always #50 sys_clk = ~sys_clk;
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            conclude();
        end
    end
    // Valid stays up after a take so back-to-back words never toggle it twice in one step.
    task automatic rdy();
        int n;
        n = 0;
        while (instr_ready !== 1'b1 && n < 20)
        begin
            instr_valid = 1'b0;
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask
    // Expected add result as nibble carry, carry and sum.
    function automatic logic [9:0] exp_add(input logic [7:0] a, input logic [7:0] b);
        exp_add = {({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F, {1'b0, a} + {1'b0, b}};
    endfunction
    task automatic exec(input logic [13:0] w);
        rdy();
        instr = w;
        instr_valid = 1'b1;
        @(posedge sys_clk);
        #1;
    endtask
    initial
    begin
        int i;
        logic [7:0] k, ea, r;
        logic [8:0] s;
        logic ez, ec, ed;
        logic [13:0] jw [8];
        logic [1:0] jo [8];
        logic [14:0] jt [4];
        logic [63:0] ed_dir;
        i = $urandom(32'h97c85112);
        ea = 8'h00;
        ez = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        `CHK({prescale_cfg, pin_dir[7:0], expiry_flag}, 17'h1_FFFF)
        for (i = 0; i < 60; i++)
        begin
            k = (i < 2) ? 8'h00 : 8'($urandom);
            file_rdata = 8'($urandom);
            case ($urandom % 4)
                0: begin {ed, s} = exp_add(ea, k); ea = s[7:0];
                   ez = (ea == 8'h00); exec({6'h3E, k});
                   `CHK({carry_flag, nibble_outflow_flag}, {s[8], ed}) end
                1: begin ea = ea & k; ez = (ea == 8'h00); exec({6'h39, k}); end
                2: begin ea = k; exec({6'h34, k}); `CHK(pc_op, 2'h3) end
                default: begin r = ea & file_rdata; ez = (r == 8'h00); exec({6'h05, k});
                   if (k[7]) `CHK({file_wr, file_addr, file_wdata}, {1'b1, k[6:0], r})
                   else ea = r; end
            endcase
            `CHK(acc, ea)
            `CHK(zero_flag, ez)
        end
        jw = '{14'h33F0, 14'h000B, 14'h25A5, 14'h2AA3, 14'h000A, 14'h0008, 14'h0009, 14'h3412};
        jo = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
        jt = '{15'h7FF0, {7'h00, ea}, 15'h05A5, 15'h02A3};
        for (i = 0; i < 8; i++)
        begin
            exec(jw[i]);
            `CHK({pc_op, pc_load, instr_ready}, {jo[i], 2'h2})
            if (i < 4) `CHK(pc_target, jt[i])
            if (i == 6) `CHK(pc_target[0], 1'b1)
        end
        ea = 8'h12;
        exec(14'h0063);
        `CHK({standby, expiry_flag, sleep_entered_flag}, 3'h6)
        exec(14'h0064);
        `CHK({watchdog_kick, expiry_flag, sleep_entered_flag}, 3'h7)
        exec(14'h343C);
        ea = 8'h3C;
        exec(14'h0062);
        `CHK({prescale_cfg, zero_flag}, {ea, ez})
        ed_dir = 64'hFFFF_FFFF_FFFF_FFFF;
        foreach (jo[i])
            if (i < 2 || i > 4)
            begin
                exec({11'h00C, 3'(i)});
                ed_dir[i*8 +: 8] = ea;
            end
        `CHK(pin_dir, ed_dir)
        exec(14'h3120);
        `CHK(ptr0, 16'hFFE0)
        exec(14'h315F);
        `CHK(ptr1, 16'h001F)
        mv = 8'($urandom);
        exec(14'h0016);
        `CHK({mem_addr, acc, ptr1, zero_flag}, {16'h001F, mv, 16'h0020, mv == 8'h00})
        `CHK(mem_rd, 1'b1)
        ez = (mv == 8'h00);
        exec(14'h001D);
        `CHK({mem_wr, mem_addr, mem_wdata, ptr1}, {1'b1, 16'h001F, mv, 16'h001F})
        mv = 8'hA5;
        exec(14'h3F45);
        `CHK({mem_rd, mem_addr, acc, zero_flag}, {1'b1, 16'h0024, mv, 1'b0})
        exec(14'h3FC3);
        `CHK({mem_wr, mem_addr, mem_wdata, zero_flag}, {1'b1, 16'h0022, mv, 1'b0})
        mv = 8'h00;
        exec(14'h3F00);
        `CHK(instr_ready, 1'b0)
        rdy();
        `CHK({acc, zero_flag}, {8'h00, 1'b1})
        exec(14'h0013);
        `CHK({mem_rd, mem_addr, ptr0, instr_ready}, {1'b1, 16'hFFE0, 16'hFFDF, 1'b0})
        exec(14'h0018);
        `CHK({mem_wr, mem_addr, ptr0, instr_ready}, {1'b1, 16'hFFE0, 16'hFFE0, 1'b0})
        rdy();
        conclude();
    end
endmodule
`default_nettype wire
